// ### core/ebm_block_memory.sv
// Embedded block memory: two-port RAM or single-clock FIFO over one 9-kbit array.
// How it works
// - Nine kilobit array with input and output registers.
// - Single, dual, pseudo dual or FIFO; 8192x1..1024x9.
// - FIFO also allows 512x18; RAM allows it on one port only.
// - Each port chooses its own data width.
// - Words packed linearly from bit zero upward.
// - Contents optionally preloaded before operation.
// - Address and write data registered before array.
// - Optional output register adds one cycle.
// - Rising edge; controls active high except nrst and global_clear_n.
// - Normal mode hides data during writes.
// - Write-through shows written data on output.
// - Read-before-write shows old contents on output.
// - FIFO has separate write and read controls.
// - FIFO flags derived internally from pointers.
// - Full and almost-full registered on write side.
// - Empty and almost-empty registered on read side.
// - Feedback inputs act as FIFO chip selects.
// - Output read gate gates read data update.
// - Each port has a complete independent set.
// - Read pointer rewind leaves data, write pointer.
// - Flag thresholds programmable; empty fixed at zero.
// - FIFO clear empties pointers and resets flags.
// - Port clears and global clear zero outputs.
`timescale 1ns/1ps
`default_nettype none

module ebm_block_memory #(
    parameter ebm_pkg::ebm_mode_type MODE = ebm_pkg::EBM_MODE_RAM,
    parameter int A_WIDTH = 9,
    parameter int B_WIDTH = 9,
    parameter int FIFO_WIDTH = 18,
    parameter ebm_pkg::ebm_wmode_type A_WMODE = ebm_pkg::EBM_WR_NORMAL,
    parameter ebm_pkg::ebm_wmode_type B_WMODE = ebm_pkg::EBM_WR_NORMAL,
    parameter bit A_OUT_REG = 1'b0,
    parameter bit B_OUT_REG = 1'b0,
    parameter logic [ebm_pkg::EBM_BITS-1:0] INIT_BITS = '0
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic global_clear_n,
    input wire logic a_clk_en,
    input wire logic a_sel,
    input wire ebm_pkg::ebm_req_type a_req,
    input wire logic a_output_register_enable,
    input wire logic port_a_output_clear,
    output logic [17:0] a_dout,
    input wire logic b_clk_en,
    input wire logic b_sel,
    input wire ebm_pkg::ebm_req_type b_req,
    input wire logic b_output_register_enable,
    input wire logic port_b_output_clear,
    output logic [17:0] b_dout,
    input wire logic write_side_clock_enable,
    input wire logic fifo_write_en,
    input wire logic [17:0] fifo_din,
    input wire logic full_feedback_in,
    input wire logic read_side_clock_enable,
    input wire logic fifo_read_en,
    input wire logic empty_feedback_in,
    input wire logic output_read_gate,
    input wire logic read_pointer_rewind,
    input wire logic fifo_clear,
    input wire logic [12:0] full_level,
    input wire logic [12:0] almost_full_level,
    input wire logic [12:0] almost_empty_level,
    output var ebm_pkg::ebm_flags_type fifo_flags,
    output logic [17:0] fifo_dout,
    output logic fifo_dout_valid,
    input wire logic fifo_dout_ready
);
    import ebm_pkg::*;

    localparam bit IS_FIFO = (MODE == EBM_MODE_FIFO);
    localparam int FD = ebm_depth_of(FIFO_WIDTH);
    localparam int FAW = $clog2(FD);

    // The widest shape is accepted on every port here; two 18-bit RAM ports are refused below.
    if (!ebm_width_ok(A_WIDTH, 1'b1) || !ebm_width_ok(B_WIDTH, 1'b1) ||
        !ebm_width_ok(FIFO_WIDTH, 1'b1)) begin : g_bad_width
        $error("Unsupported port width.");
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // Storage has no reset so that preloaded contents survive a reset.
    logic [EBM_BITS-1:0] mem_reg = INIT_BITS;
    logic [EBM_BITS-1:0] mem_next;
    logic [EBM_BITS-1:0] wmask [2];
    logic [EBM_BITS-1:0] wdata [2];
    ebm_req_type req_eff [2];
    logic en_eff [2];
    logic output_register_enable [2];
    logic port_clear [2];
    ebm_req_type in_reg [2];
    logic in_vld_reg [2];
    logic [17:0] raw_reg [2];
    logic [17:0] out_reg [2];
    logic [17:0] dout_sel [2];

    logic [FAW:0] wr_ptr_reg;
    logic [FAW:0] rd_ptr_reg;
    logic [FAW:0] wr_ptr_next;
    logic [FAW:0] rd_ptr_next;
    logic [FAW:0] count_next;
    logic [13:0] count_ext;
    logic wr_try;
    logic rd_try;
    logic wr_go;
    logic rd_go;
    logic room;
    logic gate1_reg;
    logic gate2_reg;
    logic stage2_reg;
    logic push;
    logic pop;
    logic [1:0] buf_cnt_reg;
    logic [1:0] buf_cnt_next;
    logic [2:0] occupancy;
    logic [17:0] buf0_reg;
    logic [17:0] buf1_reg;
    ebm_flags_type flags_next;

    // FIFO selects and pointer moves.
    assign wr_try = write_side_clock_enable && fifo_write_en && full_feedback_in;
    assign rd_try = read_side_clock_enable && fifo_read_en && empty_feedback_in;
    assign occupancy = 3'(buf_cnt_reg) + 3'(in_vld_reg[1] && IS_FIFO) + 3'(stage2_reg);
    assign room = occupancy < 3'(EBM_BUF_DEPTH);
    assign wr_go = IS_FIFO && wr_try && !fifo_flags.full;
    // A read taken during a clear would otherwise push a stale word after the flush.
    assign rd_go = IS_FIFO && rd_try && !fifo_flags.empty && room && !fifo_clear;
    assign wr_ptr_next = fifo_clear ? '0 : wr_ptr_reg + (FAW + 1)'(wr_go);
    // Rewinding is exact only while the writer has not yet wrapped the array.
    assign rd_ptr_next = (fifo_clear || read_pointer_rewind) ? '0 :
                         rd_ptr_reg + (FAW + 1)'(rd_go);
    assign count_next = wr_ptr_next - rd_ptr_next;
    assign count_ext = 14'(count_next);
    assign flags_next.full = count_ext >= {1'b0, full_level};
    assign flags_next.almost_full = count_ext >= {1'b0, almost_full_level};
    assign flags_next.almost_empty = count_ext <= {1'b0, almost_empty_level};
    assign flags_next.empty = count_ext == 14'h0000;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fifo_flags <= '{EBM_FULL_RST, EBM_FULL_RST, EBM_EMPTY_RST, EBM_EMPTY_RST};
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            fifo_flags <= flags_next;
        end
    end

    a_full_blocks: assert property ((fifo_flags.full && !fifo_clear) |=>
        wr_ptr_reg == $past(wr_ptr_reg)) else $error("Write accepted while full.");
    a_empty_blocks: assert property ((fifo_flags.empty && !fifo_clear && !read_pointer_rewind)
        |=> rd_ptr_reg == $past(rd_ptr_reg)) else $error("Read accepted while empty.");
    a_empty_tracks: assert property (fifo_flags.empty == (wr_ptr_reg == rd_ptr_reg))
        else $error("Empty flag does not match the pointers.");
    a_full_level: assert property (##1 fifo_flags.full ==
        (14'((FAW + 1)'(wr_ptr_reg - rd_ptr_reg)) >= {1'b0, $past(full_level)}))
        else $error("Full flag does not match its threshold.");
    a_rewind_keeps: assert property ((read_pointer_rewind && !fifo_clear && !wr_go) |=>
        rd_ptr_reg == '0 && $stable(wr_ptr_reg)) else $error("Rewind disturbed the writer.");
    a_clear_empties: assert property (fifo_clear |=> fifo_flags.empty && !fifo_flags.full &&
        wr_ptr_reg == '0) else $error("FIFO clear left data behind.");

    // Port steering: in FIFO use port A writes and port B reads.
    assign req_eff[0] = IS_FIFO ? {1'b1, 13'(wr_ptr_reg[FAW-1:0]), fifo_din} : a_req;
    assign req_eff[1] = IS_FIFO ? {1'b0, 13'(rd_ptr_reg[FAW-1:0]), 18'h00000} : b_req;
    assign en_eff[0] = IS_FIFO ? wr_go : (a_clk_en && a_sel);
    assign en_eff[1] = IS_FIFO ? rd_go : (b_clk_en && b_sel);
    assign output_register_enable[0] = a_output_register_enable;
    assign output_register_enable[1] = b_output_register_enable;
    assign port_clear[0] = port_a_output_clear;
    assign port_clear[1] = port_b_output_clear;

    for (genvar p = 0; p < 2; p++) begin : g_port
        localparam int W = IS_FIFO ? FIFO_WIDTH : ((p == 0) ? A_WIDTH : B_WIDTH);
        localparam ebm_wmode_type WM = (p == 0) ? A_WMODE : B_WMODE;
        localparam bit OREG = (p == 0) ? A_OUT_REG : B_OUT_REG;
        localparam int D = ebm_depth_of(W);
        logic [13:0] base;
        logic [W-1:0] word;
        logic [W-1:0] raw_next;
        logic wr_hit;
        logic clr;

        if (!IS_FIFO && W == 18 && p == 0 && B_WIDTH == 18) begin : g_wide_check
            $error("Two-way 18-bit ports are not available.");
        end

        assign base = 14'(in_reg[p].addr % D) * 14'(W);
        assign word = mem_reg[base +: W];
        assign wr_hit = in_vld_reg[p] && in_reg[p].we;
        assign clr = port_clear[p] || !global_clear_n;
        assign wmask[p] = wr_hit ? (EBM_BITS'({W{1'b1}}) << base) : '0;
        assign wdata[p] = EBM_BITS'(in_reg[p].din[W-1:0]) << base;
        // Normal holds the last read; the other two modes show a value on writes.
        assign raw_next = !wr_hit ? word :
                          (WM == EBM_WR_THROUGH) ? in_reg[p].din[W-1:0] :
                          (WM == EBM_WR_READ_FIRST) ? word :
                          raw_reg[p][W-1:0];
        assign dout_sel[p] = OREG ? out_reg[p] : raw_reg[p];

        always_ff @(posedge core_clk) begin
            if (!nrst) begin
                in_reg[p] <= '0;
                in_vld_reg[p] <= 1'b0;
            end else begin
                in_vld_reg[p] <= en_eff[p];
                if (en_eff[p]) begin
                    in_reg[p] <= req_eff[p];
                end
            end
        end

        always_ff @(posedge core_clk) begin
            if (!nrst || clr) begin
                raw_reg[p] <= EBM_DOUT_RST;
                out_reg[p] <= EBM_DOUT_RST;
            end else begin
                if (in_vld_reg[p]) begin
                    raw_reg[p] <= 18'(raw_next);
                end
                if (output_register_enable[p]) begin
                    out_reg[p] <= raw_reg[p];
                end
            end
        end

        a_through_shows: assert property ((WM == EBM_WR_THROUGH && wr_hit && !clr) |=>
            raw_reg[p][W-1:0] == $past(in_reg[p].din[W-1:0]))
            else $error("Write-through value missing.");
        a_normal_hides: assert property ((WM == EBM_WR_NORMAL && wr_hit && !clr) |=>
            $stable(raw_reg[p])) else $error("Normal write changed the output.");
        a_old_shown: assert property ((WM == EBM_WR_READ_FIRST && wr_hit && !clr) |=>
            raw_reg[p][W-1:0] == $past(word)) else $error("Old contents not shown.");
        a_input_staged: assert property ((en_eff[p] && !IS_FIFO) |=> in_vld_reg[p] &&
            in_reg[p] == $past(req_eff[p]) && ((wmask[p] != '0) == in_reg[p].we))
            else $error("Request was not staged before the array.");
    end

    // Port B after port A, so B wins a same-cycle collision.
    assign mem_next = (((mem_reg & ~wmask[0]) | (wdata[0] & wmask[0])) & ~wmask[1]) |
                      (wdata[1] & wmask[1]);

    always_ff @(posedge core_clk) begin
        mem_reg <= mem_next;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            a_dout <= EBM_DOUT_RST;
            b_dout <= EBM_DOUT_RST;
        end else begin
            a_dout <= dout_sel[0];
            b_dout <= dout_sel[1];
        end
    end

    a_global_clear: assert property (!global_clear_n |=> ##1 a_dout == EBM_DOUT_RST &&
        b_dout == EBM_DOUT_RST) else $error("Global clear left output data.");

    // Two-entry buffer on the FIFO read path; reads are reserved against free slots.
    assign push = IS_FIFO && stage2_reg && gate2_reg;
    assign pop = fifo_dout_valid && fifo_dout_ready;
    assign buf_cnt_next = buf_cnt_reg + 2'(push) - 2'(pop);

    always_ff @(posedge core_clk) begin
        if (!nrst || fifo_clear) begin
            stage2_reg <= 1'b0;
            gate1_reg <= 1'b0;
            gate2_reg <= 1'b0;
            buf_cnt_reg <= EBM_BUF_CNT_RST;
            fifo_dout_valid <= 1'b0;
        end else begin
            stage2_reg <= IS_FIFO && in_vld_reg[1];
            gate1_reg <= output_read_gate;
            gate2_reg <= gate1_reg;
            buf_cnt_reg <= buf_cnt_next;
            fifo_dout_valid <= buf_cnt_next != 2'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            buf0_reg <= EBM_DOUT_RST;
            buf1_reg <= EBM_DOUT_RST;
        end else begin
            if (pop) begin
                buf0_reg <= (buf_cnt_reg == 2'h2) ? buf1_reg : raw_reg[1];
            end else if (buf_cnt_reg == 2'h0) begin
                buf0_reg <= raw_reg[1];
            end
            if (push && (buf_cnt_reg - 2'(pop)) == 2'h1) begin
                buf1_reg <= raw_reg[1];
            end
        end
    end

    assign fifo_dout = buf0_reg;

    a_buffer_bound: assert property (buf_cnt_reg <= 2'h2 && occupancy <= 3'h2)
        else $error("Read buffer overfilled.");
    a_stall_holds: assert property ((fifo_dout_valid && !fifo_dout_ready && !fifo_clear) |=>
        fifo_dout_valid && $stable(fifo_dout)) else $error("Stalled word was lost.");
    a_gate_drops: assert property ((IS_FIFO && stage2_reg && !gate2_reg && !pop &&
        !fifo_clear) |=> $stable(buf_cnt_reg)) else $error("Gated read updated the output.");

endmodule

`default_nettype wire

// ### core/ebm_pkg.sv
// Shared constants, types and helpers for the embedded block memory.
package ebm_pkg;
    localparam int EBM_BITS = 9216;
    localparam int EBM_PLAIN_BITS = 8192;
    localparam int EBM_ADDR_MAX = 13;
    localparam int EBM_DATA_MAX = 18;
    localparam int EBM_BUF_DEPTH = 2;
    localparam logic [17:0] EBM_DOUT_RST = 18'h00000;
    localparam logic [1:0] EBM_BUF_CNT_RST = 2'h0;
    localparam logic EBM_EMPTY_RST = 1'b1;
    localparam logic EBM_FULL_RST = 1'b0;

    typedef enum logic {
        EBM_MODE_RAM = 1'b0,
        EBM_MODE_FIFO = 1'b1
    } ebm_mode_type;

    typedef enum logic [1:0] {
        EBM_WR_NORMAL = 2'h0,
        EBM_WR_THROUGH = 2'h1,
        EBM_WR_READ_FIRST = 2'h2
    } ebm_wmode_type;

    typedef struct packed {
        logic we;
        logic [12:0] addr;
        logic [17:0] din;
    } ebm_req_type;

    typedef struct packed {
        logic full;
        logic almost_full;
        logic almost_empty;
        logic empty;
    } ebm_flags_type;

    // Widths that are multiples of nine use the parity bits as well.
    function automatic int ebm_depth_of(input int width);
        return (width % 9 == 0) ? EBM_BITS / width : EBM_PLAIN_BITS / width;
    endfunction

    function automatic bit ebm_width_ok(input int width, input bit wide_ok);
        return width == 1 || width == 2 || width == 4 || width == 9 ||
               (wide_ok && width == 18);
    endfunction
endpackage

// ### testbench/ebm_consumer.sv
// Consumer model that takes words from the output buffer and can stall.
`timescale 1ns/1ps
`default_nettype none

module ebm_consumer (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic stall,
    input wire logic valid,
    input wire logic [17:0] data,
    output logic ready
);
    import ebm_pkg::*;
    logic [17:0] got[$];

    // A stall holds ready low for as long as the bench asks, so a buffer that drops words shows.
    assign ready = !stall;

    always @(posedge core_clk) begin
        if (nrst && valid && ready) begin
            got.push_back(data);
        end
    end
endmodule

`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the block memory in RAM and FIFO mode.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import ebm_pkg::*;
    logic core_clk = 1'b0, nrst = 1'b0, global_clear_n = 1'b1, stall = 1'b1;
    logic a_clk_en = 1'b0, a_sel = 1'b0, b_clk_en = 1'b0, b_sel = 1'b0;
    logic a_output_register_enable = 1'b1, b_output_register_enable = 1'b1;
    logic port_a_output_clear = 1'b0, port_b_output_clear = 1'b0;
    ebm_req_type a_req = '0, b_req = '0;
    logic write_side_clock_enable = 1'b1, fifo_write_en = 1'b0, full_feedback_in = 1'b1;
    logic read_side_clock_enable = 1'b1, fifo_read_en = 1'b0, empty_feedback_in = 1'b1;
    logic output_read_gate = 1'b1, read_pointer_rewind = 1'b0, fifo_clear = 1'b0;
    logic [17:0] fifo_din = '0;
    logic [17:0] a_dout, b_dout, fifo_dout, q, t_dout;
    logic [12:0] full_level = 13'h0004, almost_full_level = 13'h0003;
    logic [12:0] almost_empty_level = 13'h0001;
    ebm_flags_type fifo_flags;
    logic fifo_dout_valid, fifo_dout_ready;
    int n_fail = 0, check_count = 0;

    always #5 core_clk = ~core_clk;

    ebm_block_memory #(.A_WIDTH(9), .B_WIDTH(4), .B_WMODE(EBM_WR_READ_FIRST),
        .A_OUT_REG(1'b1), .INIT_BITS(9216'h155)) i_ebm_block_memory (
        .core_clk, .nrst, .global_clear_n, .a_clk_en, .a_sel, .a_req, .a_output_register_enable,
        .port_a_output_clear, .a_dout, .b_clk_en, .b_sel, .b_req, .b_output_register_enable,
        .port_b_output_clear, .b_dout, .write_side_clock_enable, .fifo_write_en, .fifo_din,
        .full_feedback_in, .read_side_clock_enable, .fifo_read_en, .empty_feedback_in,
        .output_read_gate, .read_pointer_rewind, .fifo_clear, .full_level, .almost_full_level,
        .almost_empty_level, .fifo_flags(), .fifo_dout(), .fifo_dout_valid(), .fifo_dout_ready);

    // Second copy with a write-through port A, fed the same requests as the first.
    ebm_block_memory #(.A_WMODE(EBM_WR_THROUGH), .INIT_BITS(9216'h155)) i_ebm_block_memory_thru (
        .core_clk, .nrst, .global_clear_n, .a_clk_en, .a_sel, .a_req, .a_output_register_enable,
        .port_a_output_clear, .a_dout(t_dout), .b_clk_en, .b_sel, .b_req,
        .b_output_register_enable, .port_b_output_clear, .b_dout(), .write_side_clock_enable,
        .fifo_write_en, .fifo_din, .full_feedback_in, .read_side_clock_enable, .fifo_read_en,
        .empty_feedback_in, .output_read_gate, .read_pointer_rewind, .fifo_clear, .full_level,
        .almost_full_level, .almost_empty_level, .fifo_flags(), .fifo_dout(),
        .fifo_dout_valid(), .fifo_dout_ready);

    ebm_block_memory #(.MODE(EBM_MODE_FIFO), .FIFO_WIDTH(18)) i_ebm_block_memory_fifo (
        .core_clk, .nrst, .global_clear_n, .a_clk_en, .a_sel, .a_req, .a_output_register_enable,
        .port_a_output_clear, .a_dout(), .b_clk_en, .b_sel, .b_req, .b_output_register_enable,
        .port_b_output_clear, .b_dout(), .write_side_clock_enable, .fifo_write_en, .fifo_din,
        .full_feedback_in, .read_side_clock_enable, .fifo_read_en, .empty_feedback_in,
        .output_read_gate, .read_pointer_rewind, .fifo_clear, .full_level, .almost_full_level,
        .almost_empty_level, .fifo_flags, .fifo_dout, .fifo_dout_valid, .fifo_dout_ready);

    ebm_consumer i_ebm_consumer (.core_clk, .nrst, .stall, .valid(fifo_dout_valid),
        .data(fifo_dout), .ready(fifo_dout_ready));

    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One request on port A or B; the answer is read once the port's latency has passed.
    task automatic ram(input bit pb, input logic we, input logic [12:0] ad,
                       input logic [17:0] d, output logic [17:0] rd);
        @(negedge core_clk);
        if (pb) begin
            b_clk_en = 1'b1;
            b_sel = 1'b1;
            b_req = {we, ad, d};
        end else begin
            a_clk_en = 1'b1;
            a_sel = 1'b1;
            a_req = {we, ad, d};
        end
        @(negedge core_clk);
        {a_clk_en, a_sel, b_clk_en, b_sel} = 4'h0;
        repeat (pb ? 3 : 4) @(negedge core_clk);
        rd = pb ? b_dout : a_dout;
    endtask

    task automatic rd_for(input int n);
        fifo_read_en = 1'b1;
        repeat (n) @(negedge core_clk);
        fifo_read_en = 1'b0;
        repeat (6) @(negedge core_clk);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #50us;
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        repeat (12) @(negedge core_clk);
        nrst = 1'b1;
        @(negedge core_clk);
        chk(a_dout | b_dout, 18'h00000);
        chk({13'h0000, fifo_flags, fifo_dout_valid}, 18'h00006);
        ram(1'b0, 1'b0, 13'h0000, 18'h00000, q);
        chk(q, 18'h00155);
        ram(1'b0, 1'b1, 13'h0006, 18'h001A5, q);
        chk(q, 18'h00155);
        chk(t_dout, 18'h001A5);
        ram(1'b1, 1'b0, 13'h000E, 18'h00000, q);
        chk(q, 18'h00009);
        ram(1'b1, 1'b1, 13'h000E, 18'h00006, q);
        chk(q, 18'h00009);
        ram(1'b0, 1'b0, 13'h0006, 18'h00000, q);
        chk(q, 18'h00199);
        port_a_output_clear = 1'b1;
        @(negedge core_clk);
        port_a_output_clear = 1'b0;
        @(negedge core_clk);
        chk(a_dout, 18'h00000);
        chk(b_dout, 18'h00009);
        global_clear_n = 1'b0;
        @(negedge core_clk);
        global_clear_n = 1'b1;
        @(negedge core_clk);
        chk(b_dout, 18'h00000);
        chk(t_dout, 18'h00000);
        $display("ram port test done");

        // Five writes against a level of four: the last one must be dropped.
        for (int k = 0; k < 5; k++) begin
            @(negedge core_clk);
            fifo_din = 18'h2A000 | 18'(k);
            fifo_write_en = 1'b1;
        end
        @(negedge core_clk);
        fifo_write_en = 1'b0;
        repeat (2) @(negedge core_clk);
        chk({14'h0000, fifo_flags}, 18'h0000C);
        rd_for(10);
        chk({17'h00000, fifo_dout_valid}, 18'h00001);
        chk(fifo_dout, 18'h2A000);
        chk({14'h0000, fifo_flags}, 18'h00000);
        stall = 1'b0;
        rd_for(12);
        chk(18'(i_ebm_consumer.got.size()), 18'h00004);
        for (int k = 0; k < 4; k++) begin
            chk(i_ebm_consumer.got[k], 18'h2A000 | 18'(k));
        end
        chk({14'h0000, fifo_flags}, 18'h00003);
        $display("fifo fill and drain test done");

        read_pointer_rewind = 1'b1;
        @(negedge core_clk);
        read_pointer_rewind = 1'b0;
        repeat (3) @(negedge core_clk);
        chk({14'h0000, fifo_flags}, 18'h0000C);
        output_read_gate = 1'b0;
        rd_for(1);
        output_read_gate = 1'b1;
        chk(18'(i_ebm_consumer.got.size()), 18'h00004);
        rd_for(12);
        chk(18'(i_ebm_consumer.got.size()), 18'h00007);
        for (int k = 1; k < 4; k++) begin
            chk(i_ebm_consumer.got[k + 3], 18'h2A000 | 18'(k));
        end
        fifo_write_en = 1'b1;
        @(negedge core_clk);
        fifo_write_en = 1'b0;
        stall = 1'b1;
        rd_for(2);
        chk({17'h00000, fifo_dout_valid}, 18'h00001);
        fifo_clear = 1'b1;
        @(negedge core_clk);
        fifo_clear = 1'b0;
        @(negedge core_clk);
        chk({13'h0000, fifo_flags, fifo_dout_valid}, 18'h00006);
        full_feedback_in = 1'b0;
        fifo_write_en = 1'b1;
        @(negedge core_clk);
        fifo_write_en = 1'b0;
        full_feedback_in = 1'b1;
        repeat (2) @(negedge core_clk);
        chk({14'h0000, fifo_flags}, 18'h00003);
        fifo_write_en = 1'b1;
        @(negedge core_clk);
        fifo_write_en = 1'b0;
        empty_feedback_in = 1'b0;
        rd_for(2);
        empty_feedback_in = 1'b1;
        chk({13'h0000, fifo_flags, fifo_dout_valid}, 18'h00004);
        stall = 1'b0;
        $display("fifo rewind and clear test done");
        report_and_stop();
    end
endmodule

`default_nettype wire
